/* File: crc_engine_control.sv */
/*
  CRC engine with its control, data and overlay registers behind an AXI4-Lite slave,
  plus the word path from the memory scanner through a small FIFO.
  Assumes one clock, synchronous active-low reset, scanner and sleep inputs synchronous to aclk.
*/
// Implementation choice: the AXI4-Lite slave port.
// Behaviour
// - sleep freezes engine state until wake
// - each module disable bit holds its block off
// - scanner disable only counts with fuse set
// - enable bit releases engine, clear holds it
// - start bit runs serial shifter, clear stops
// - busy high while shifting or word pending
// - zero augment appends zeros after data
// - overlay select picks output, shifter, taps
// - direction one shifts LSb first, else MSb
// - full flag high until word enters shifter
// - poly length holds length minus one
// - data length holds bits minus one
// - data input split into four byte lanes
// - control and data registers reset zero
// - clearing enable also clears scanner go
module crc_engine_control
  import crc_engine_pkg::*;
#(
  parameter int FIFO_DEPTH = SCAN_FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_active,
  input wire logic scanner_fuse_enable,
  input wire logic [31:0] scan_data,
  input wire logic scan_valid,
  output logic scan_ready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("crc_engine_control needs FIFO_DEPTH >= 2");
    end
  end

  function automatic logic mapped(input logic [13:0] idx);
    return idx == IDX_DATA_INPUT || idx == IDX_OVERLAY || idx == IDX_CONTROL_MAIN ||
           idx == IDX_POLY_LENGTH || idx == IDX_DATA_LENGTH || idx == IDX_MODULE_DISABLE ||
           idx == IDX_SCANNER_CTRL;
  endfunction : mapped

  function automatic logic [31:0] len_mask(input logic [LEN_W-1:0] len);
    logic [32:0] t;
    t = (33'h1 << ({1'b0, len} + 6'h1)) - 33'h1;
    return t[31:0];
  endfunction : len_mask

  // one accumulator step; the right-shift form expects the taps given reflected
  function automatic logic [31:0] crc_step(input logic [31:0] acc, input logic b, input logic [31:0] taps,
                                          input logic [LEN_W-1:0] poly_length, input logic aug, input logic right);
    logic fb;
    logic [31:0] n;
    fb = 1'b0;
    n = acc;
    if (right) begin
      fb = aug ? acc[0] : (acc[0] ^ b);
      n = (acc >> 1) | ((aug ? {31'h0, b} : 32'h0) << poly_length);
    end else begin
      fb = aug ? acc[poly_length] : (acc[poly_length] ^ b);
      n = (acc << 1) | (aug ? {31'h0, b} : 32'h0);
    end
    return (n ^ (fb ? taps : 32'h0)) & len_mask(poly_length);
  endfunction : crc_step

  logic enable_reg, start_reg, zero_aug_reg, shift_dir_reg, data_full_reg;
  logic [1:0] overlay_sel_reg;
  logic [LEN_W-1:0] poly_length_reg, data_word_length_reg;
  logic [31:0] data_input_reg, acc_reg, taps_reg, shifter_reg;
  logic [5:0] data_left_reg, zero_left_reg;
  logic crc_md_reg, scan_md_reg, scanner_go_reg, scan_ready_reg;
  logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [13:0] aw_idx_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  logic wr_do, rd_do, engine_run, scanner_on, busy, shifter_empty, load_shifter;
  logic [13:0] rd_idx;
  logic fifo_out_valid, fifo_pop, sw_data_launch;
  logic [31:0] fifo_out_data;
  logic [LW-1:0] fifo_level;

  assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_do = s_axi_arvalid && arready_reg;
  assign rd_idx = s_axi_araddr[15:2];
  assign engine_run = enable_reg && !crc_md_reg;
  assign scanner_on = scanner_fuse_enable && !(scanner_fuse_enable && scan_md_reg) && scanner_go_reg && engine_run;
  assign shifter_empty = (data_left_reg == '0) && (zero_left_reg == '0);
  assign busy = data_full_reg || !shifter_empty;
  assign load_shifter = engine_run && !sleep_active && start_reg && data_full_reg && shifter_empty;
  assign sw_data_launch = wr_do && aw_idx_reg == IDX_DATA_INPUT && wstrb_reg[0];
  assign fifo_pop = fifo_out_valid && scanner_on && !sleep_active && !data_full_reg &&
                    !(wr_do && aw_idx_reg == IDX_DATA_INPUT);

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign scan_ready = scan_ready_reg;

  scan_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_scan_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(scan_valid && scan_ready_reg),
    .in_ready(),
    .in_data(scan_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ready is registered, so keep one slot spare for the word taken in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_ready_reg <= 1'b0;
    end else begin
      scan_ready_reg <= scanner_on && !sleep_active && (fifo_level < LW'(FIFO_DEPTH - 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_idx_reg <= '0;
      wdata_reg <= WORD_RESET;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_hold_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_idx_reg <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && wready_reg) begin
        w_hold_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_idx_reg) ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= WORD_RESET;
      rresp_reg <= RESP_OKAY;
    end else if (rd_do) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
      unique case (rd_idx)
        IDX_DATA_INPUT: rdata_reg <= data_input_reg;
        IDX_OVERLAY: rdata_reg <= (overlay_sel_reg == OVL_SHIFTER) ? shifter_reg :
                                  (overlay_sel_reg == OVL_TAPS) ? taps_reg : acc_reg;
        IDX_CONTROL_MAIN: rdata_reg <= {24'h0, enable_reg, start_reg, busy, zero_aug_reg,
                                        overlay_sel_reg, shift_dir_reg, data_full_reg};
        IDX_POLY_LENGTH: rdata_reg <= {27'h0, poly_length_reg};
        IDX_DATA_LENGTH: rdata_reg <= {27'h0, data_word_length_reg};
        IDX_MODULE_DISABLE: rdata_reg <= {30'h0, scan_md_reg, crc_md_reg};
        IDX_SCANNER_CTRL: rdata_reg <= {30'h0, scanner_fuse_enable, scanner_go_reg};
        default: rdata_reg <= WORD_RESET;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {enable_reg, start_reg, zero_aug_reg, overlay_sel_reg, shift_dir_reg} <= CONTROL_MAIN_RESET[7:2];
      poly_length_reg <= LENGTH_RESET;
      data_word_length_reg <= LENGTH_RESET;
      crc_md_reg <= 1'b0;
      scan_md_reg <= 1'b0;
    end else if (wr_do && wstrb_reg[0]) begin
      if (aw_idx_reg == IDX_CONTROL_MAIN) begin
        enable_reg <= wdata_reg[BIT_ENABLE];
        start_reg <= wdata_reg[BIT_START];
        zero_aug_reg <= wdata_reg[BIT_ZERO_AUG];
        overlay_sel_reg <= wdata_reg[BIT_OVL_HI:BIT_OVL_LO];
        shift_dir_reg <= wdata_reg[BIT_SHIFT_DIR];
      end
      if (aw_idx_reg == IDX_POLY_LENGTH) begin
        poly_length_reg <= wdata_reg[LEN_W-1:0];
      end
      if (aw_idx_reg == IDX_DATA_LENGTH) begin
        data_word_length_reg <= wdata_reg[LEN_W-1:0];
      end
      if (aw_idx_reg == IDX_MODULE_DISABLE) begin
        crc_md_reg <= wdata_reg[BIT_CRC_MD];
        scan_md_reg <= wdata_reg[BIT_SCAN_MD];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scanner_go_reg <= 1'b0;
    end else if (!engine_run) begin
      scanner_go_reg <= 1'b0;
    end else if (wr_do && wstrb_reg[0] && aw_idx_reg == IDX_SCANNER_CTRL) begin
      scanner_go_reg <= wdata_reg[BIT_SCAN_GO];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_input_reg <= WORD_RESET;
    end else if (wr_do && aw_idx_reg == IDX_DATA_INPUT) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_reg[i]) begin
          data_input_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
        end
      end
    end else if (fifo_pop) begin
      data_input_reg <= fifo_out_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_full_reg <= 1'b0;
    end else if (!engine_run) begin
      data_full_reg <= 1'b0;
    end else if (sw_data_launch || fifo_pop) begin
      data_full_reg <= 1'b1;
    end else if (load_shifter) begin
      data_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= WORD_RESET;
      taps_reg <= WORD_RESET;
      shifter_reg <= WORD_RESET;
      data_left_reg <= '0;
      zero_left_reg <= '0;
    end else begin
      if (wr_do && aw_idx_reg == IDX_OVERLAY) begin
        if (overlay_sel_reg == OVL_SHIFTER) begin
          shifter_reg <= wdata_reg;
        end else if (overlay_sel_reg == OVL_TAPS) begin
          taps_reg <= wdata_reg;
        end else begin
          acc_reg <= wdata_reg;
        end
      end
      if (!engine_run || !start_reg) begin
        data_left_reg <= '0;
        zero_left_reg <= '0;
      end else if (sleep_active) begin
        data_left_reg <= data_left_reg;
      end else if (load_shifter) begin
        shifter_reg <= data_input_reg;
        data_left_reg <= {1'b0, data_word_length_reg} + 6'h1;
        zero_left_reg <= zero_aug_reg ? {1'b0, poly_length_reg} + 6'h1 : 6'h0;
      end else if (data_left_reg != '0) begin
        if (shift_dir_reg) begin
          acc_reg <= crc_step(acc_reg, shifter_reg[0], taps_reg, poly_length_reg, zero_aug_reg, 1'b1);
          shifter_reg <= shifter_reg >> 1;
        end else begin
          acc_reg <= crc_step(acc_reg, shifter_reg[data_word_length_reg], taps_reg, poly_length_reg,
                              zero_aug_reg, 1'b0);
          shifter_reg <= shifter_reg << 1;
        end
        data_left_reg <= data_left_reg - 6'h1;
      end else if (zero_left_reg != '0) begin
        acc_reg <= crc_step(acc_reg, 1'b0, taps_reg, poly_length_reg, 1'b1, shift_dir_reg);
        zero_left_reg <= zero_left_reg - 6'h1;
      end
    end
  end

  sleep_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_active && engine_run && start_reg && $past(engine_run) |=> $stable(data_left_reg))
    else $error("shifter moved during sleep");
  crc_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    crc_md_reg |=> data_left_reg == '0 && zero_left_reg == '0) else $error("engine ran while disabled");
  scan_fuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !scanner_fuse_enable |-> !fifo_pop) else $error("scanner fed data without fuse");
  start_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    load_shifter |=> data_left_reg == {1'b0, $past(data_word_length_reg)} + 6'h1)
    else $error("shifter load count wrong");
  busy_state_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (data_left_reg != '0) |-> busy) else $error("busy low while shifting");
  zero_aug_a: assert property (@(posedge aclk) disable iff (!aresetn)
    load_shifter && !zero_aug_reg |=> zero_left_reg == '0) else $error("zeros appended without augment");
  full_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    load_shifter && !sw_data_launch && !fifo_pop |=> !data_full_reg) else $error("full stayed after load");
  go_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_reg |=> !scanner_go_reg) else $error("scanner go survived disable");
  status_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && aw_idx_reg == IDX_CONTROL_MAIN && !busy |=> !data_full_reg) else $error("full written by software");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do |=> bvalid_reg [*1]) else $error("write not answered");

  load_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) load_shifter);
  aug_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) zero_left_reg == 6'h1 && data_left_reg == '0);
  scan_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) fifo_pop);
  sleep_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) sleep_active && data_left_reg != '0);
endmodule : crc_engine_control

/* File: crc_engine_pkg.sv */
/*
  Register indices, field positions and reset values for the CRC engine.
  Assumes a 32-bit AXI4-Lite slave where each register index maps to byte address 4*index.
*/
package crc_engine_pkg;
  localparam int ADDR_W = 16;
  localparam logic [13:0] IDX_DATA_INPUT = 14'h1c9a;
  localparam logic [13:0] IDX_OVERLAY = 14'h1c9e;
  localparam logic [13:0] IDX_CONTROL_MAIN = 14'h1ca2;
  localparam logic [13:0] IDX_POLY_LENGTH = 14'h1ca3;
  localparam logic [13:0] IDX_DATA_LENGTH = 14'h1ca4;
  localparam logic [13:0] IDX_MODULE_DISABLE = 14'h1ca8;
  localparam logic [13:0] IDX_SCANNER_CTRL = 14'h1ca9;

  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_ZERO_AUG = 4;
  localparam int BIT_OVL_HI = 3;
  localparam int BIT_OVL_LO = 2;
  localparam int BIT_SHIFT_DIR = 1;
  localparam int BIT_FULL = 0;
  localparam int BIT_CRC_MD = 0;
  localparam int BIT_SCAN_MD = 1;
  localparam int BIT_SCAN_GO = 0;
  localparam int BIT_SCAN_AVAIL = 1;
  localparam int LEN_W = 5;

  localparam logic [7:0] CONTROL_MAIN_RESET = 8'h00;
  localparam logic [4:0] LENGTH_RESET = 5'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  localparam logic [1:0] OVL_SHIFTER = 2'b01;
  localparam logic [1:0] OVL_TAPS = 2'b10;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  localparam int SCAN_FIFO_DEPTH = 8;
endpackage : crc_engine_pkg

/* File: scan_fifo.sv */
/*
  Word FIFO between the memory scanner and the CRC data input register.
  Assumes a single clock and a synchronous active-low reset; storage is flip-flops.
*/
module scan_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("scan_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [LW-1:0] level_reg;
  logic push;
  logic pop;

  assign in_ready = (level_reg != LW'(DEPTH));
  assign out_valid = (level_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = level_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 1'b1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end

  fifo_no_overflow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    level_reg <= LW'(DEPTH)) else $error("fifo level above depth");
endmodule : scan_fifo

/* File: scan_source.sv */
/*
  Behavioural model of the memory scanner feeding words to the CRC block.
  Assumes one clock shared with the block; the bench raises total to ask for more words.
*/
module scan_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  input wire logic [7:0] total,
  output logic [31:0] scan_data,
  output logic scan_valid,
  input wire logic scan_ready,
  output logic [7:0] sent
);
  timeunit 1ns;
  timeprecision 1ns;

  // an offered word stays put until taken; an idle bus toggles so stale data never looks fresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_valid <= 1'b0;
      scan_data <= 32'h0000_0000;
      sent <= 8'h00;
    end else if (scan_valid && scan_ready) begin
      scan_valid <= 1'b0;
      scan_data <= ~scan_data;
      sent <= sent + 8'h01;
    end else if (!scan_valid && !hold && sent < total) begin
      scan_valid <= 1'b1;
      scan_data <= {8'hc3, sent, 8'h5a, sent * 8'h25 + 8'h01};
    end else if (!scan_valid) begin
      scan_data <= ~scan_data;
    end
  end
endmodule : scan_source

/* File: crc_engine_control_test.sv */
/*
  Self-checking bench for the CRC engine: register bus, shifter, overlay, sleep and scanner path.
  Assumes the scanner model drives the word input and the bus is the only software path.
*/
module crc_engine_control_test import crc_engine_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sleep_active = 1'b0;
  logic scanner_fuse_enable = 1'b0;
  logic src_hold = 1'b0;
  logic [7:0] src_total = 8'h00;
  logic [7:0] src_sent;
  logic [31:0] scan_data;
  logic scan_valid, scan_ready;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #20 aclk = ~aclk;

  crc_engine_control crc_engine_control_inst (.aclk(aclk), .aresetn(aresetn), .sleep_active(sleep_active),
    .scanner_fuse_enable(scanner_fuse_enable), .scan_data(scan_data), .scan_valid(scan_valid),
    .scan_ready(scan_ready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  scan_source scan_source_inst (.aclk(aclk), .aresetn(aresetn), .hold(src_hold), .total(src_total),
    .scan_data(scan_data), .scan_valid(scan_valid), .scan_ready(scan_ready), .sent(src_sent));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // every scenario together stays far below this ceiling
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [3:0] st = 4'hf,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [13:0] idx, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic ctl(input logic en, go, aug, input logic [1:0] ovl, input logic dir);
    wr(IDX_CONTROL_MAIN, {24'h0, en, go, 1'b0, aug, ovl, dir, 1'b0});
  endtask : ctl

  // busy may dip for a cycle between queued words, so idle means several quiet reads in a row
  task automatic wait_idle;
    logic [31:0] v;
    int quiet;
    quiet = 0;
    while (quiet < 3) begin
      rd(IDX_CONTROL_MAIN, v);
      quiet = (v[BIT_BUSY] === 1'b0) ? quiet + 1 : 0;
    end
  endtask : wait_idle

  function automatic logic [31:0] crc_ref(input logic [31:0] acc, d, taps, input int pl, dl, input logic aug, right);
    logic b;
    logic fb;
    logic [31:0] m;
    m = (pl == 31) ? 32'hffff_ffff : (32'h1 << (pl + 1)) - 32'h1;
    for (int i = 0; i <= dl + (aug ? pl + 1 : 0); i++) begin
      b = (i > dl) ? 1'b0 : (right ? d[i] : d[dl - i]);
      fb = (right ? acc[0] : acc[pl]) ^ (aug ? 1'b0 : b);
      acc = right ? ((acc >> 1) | ((aug ? {31'h0, b} : 32'h0) << pl)) : ((acc << 1) | (aug ? {31'h0, b} : 32'h0));
      acc = (acc ^ (fb ? taps : 32'h0)) & m;
    end
    return acc;
  endfunction : crc_ref

  task automatic setup(input logic right, aug, input int pl, dl, input logic [31:0] taps, input logic go);
    wr(IDX_POLY_LENGTH, 32'(pl));
    wr(IDX_DATA_LENGTH, 32'(dl));
    ctl(1'b1, 1'b0, aug, OVL_TAPS, right);
    wr(IDX_OVERLAY, taps);
    ctl(1'b1, 1'b0, aug, 2'b00, right);
    wr(IDX_OVERLAY, 32'h0);
    ctl(1'b1, go, aug, 2'b00, right);
  endtask : setup

  task automatic t_regs;
    logic [31:0] v;
    logic [13:0] regs [5] = '{IDX_DATA_INPUT, IDX_CONTROL_MAIN, IDX_POLY_LENGTH, IDX_DATA_LENGTH, IDX_OVERLAY};
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk("reset value", 32'h0, v);
    end
    rd(14'h1cb0, v, RESP_DECERR);
    wr(14'h1cb0, 32'h0, 4'hf, RESP_DECERR);
    wr(IDX_CONTROL_MAIN, 32'hff);
    rd(IDX_CONTROL_MAIN, v);
    chk("control readback", 32'hde, v);
    wr(IDX_CONTROL_MAIN, 32'h0);
    wr(IDX_POLY_LENGTH, 32'hff);
    rd(IDX_POLY_LENGTH, v);
    chk("poly length", 32'h1f, v);
    wr(IDX_DATA_LENGTH, 32'hff);
    rd(IDX_DATA_LENGTH, v);
    chk("data length", 32'h1f, v);
    wr(IDX_DATA_INPUT, 32'ha1b2c3d4, 4'h8);
    wr(IDX_DATA_INPUT, 32'h55667788, 4'h6);
    rd(IDX_DATA_INPUT, v);
    chk("data lanes", 32'ha16677_00, v);
    rd(IDX_CONTROL_MAIN, v);
    chk("full without low byte", 32'h0, {31'h0, v[BIT_FULL]});
    ctl(1'b0, 1'b1, 1'b0, 2'b00, 1'b0);
    wr(IDX_DATA_INPUT, 32'h5a, 4'h1);
    rd(IDX_CONTROL_MAIN, v);
    chk("launch while off", 32'h0, {30'h0, v[BIT_BUSY], v[BIT_FULL]});
    ctl(1'b1, 1'b1, 1'b0, 2'b00, 1'b0);
    wr(IDX_MODULE_DISABLE, 32'h1);
    wr(IDX_DATA_INPUT, 32'h5a, 4'h1);
    rd(IDX_CONTROL_MAIN, v);
    chk("launch while disabled", 32'h0, {30'h0, v[BIT_BUSY], v[BIT_FULL]});
    wr(IDX_MODULE_DISABLE, 32'h0);
    $display("test registers finished");
  endtask : t_regs

  task automatic t_crc(input logic right, aug, input int pl, dl, input logic [31:0] taps, d, input logic nap);
    logic [31:0] v, o, o2;
    setup(right, aug, pl, dl, taps, 1'b1);
    if (dl > 7) wr(IDX_DATA_INPUT, d, 4'he);
    wr(IDX_DATA_INPUT, d, 4'h1);
    rd(IDX_CONTROL_MAIN, v);
    chk("busy after launch", 32'h1, {31'h0, v[BIT_BUSY]});
    if (nap) begin
      sleep_active <= 1'b1;
      rd(IDX_OVERLAY, o);
      repeat (50) @(posedge aclk);
      rd(IDX_OVERLAY, o2);
      chk("frozen accumulator", o, o2);
      rd(IDX_CONTROL_MAIN, v);
      chk("busy while asleep", 32'h1, {31'h0, v[BIT_BUSY]});
      sleep_active <= 1'b0;
    end
    wait_idle;
    rd(IDX_CONTROL_MAIN, v);
    chk("full after shift", 32'h0, {31'h0, v[BIT_FULL]});
    rd(IDX_OVERLAY, o);
    chk("checksum", crc_ref(32'h0, d, taps, pl, dl, aug, right), o);
    ctl(1'b1, 1'b0, aug, 2'b11, right);
    rd(IDX_OVERLAY, v);
    chk("output alias", o, v);
    ctl(1'b1, 1'b0, aug, OVL_TAPS, right);
    rd(IDX_OVERLAY, v);
    chk("taps untouched", taps, v);
    $display("test crc dir %0d aug %0d len %0d finished", right, aug, dl + 1);
  endtask : t_crc

  task automatic t_scan;
    logic [31:0] v, acc;
    acc = 32'h0;
    setup(1'b0, 1'b0, 7, 7, 32'h07, 1'b1);
    wr(IDX_SCANNER_CTRL, 32'h1);
    rd(IDX_SCANNER_CTRL, v);
    chk("fuse reads back", 32'h0, {31'h0, v[BIT_SCAN_AVAIL]});
    src_total <= 8'd4;
    repeat (30) @(posedge aclk);
    chk("intake without fuse", 32'h0, {24'h0, src_sent});
    wr(IDX_MODULE_DISABLE, 32'h2);
    scanner_fuse_enable <= 1'b1;
    wr(IDX_SCANNER_CTRL, 32'h1);
    repeat (30) @(posedge aclk);
    chk("intake while disabled", 32'h0, {24'h0, src_sent});
    ctl(1'b1, 1'b0, 1'b0, 2'b00, 1'b0);
    wr(IDX_MODULE_DISABLE, 32'h0);
    wr(IDX_SCANNER_CTRL, 32'h1);
    src_total <= 8'd12;
    repeat (80) @(posedge aclk);
    chk("fifo refuses when full", 32'h1, {31'h0, src_sent < 8'd12});
    rd(IDX_CONTROL_MAIN, v);
    chk("word waiting", 32'h1, {31'h0, v[BIT_FULL]});
    ctl(1'b1, 1'b1, 1'b0, 2'b00, 1'b0);
    src_hold <= 1'b1;
    repeat (40) @(posedge aclk);
    src_hold <= 1'b0;
    while (src_sent !== 8'd12) @(posedge aclk);
    wait_idle;
    for (int k = 0; k < 12; k++) acc = crc_ref(acc, {24'h0, 8'(k) * 8'h25 + 8'h01}, 32'h07, 7, 7, 1'b0, 1'b0);
    rd(IDX_OVERLAY, v);
    chk("scanned checksum", acc, v);
    rd(IDX_SCANNER_CTRL, v);
    chk("scanner go set", 32'h1, {31'h0, v[BIT_SCAN_GO]});
    ctl(1'b0, 1'b0, 1'b0, 2'b00, 1'b0);
    rd(IDX_SCANNER_CTRL, v);
    chk("scanner go cleared", 32'h0, {31'h0, v[BIT_SCAN_GO]});
    $display("test scanner finished");
  endtask : t_scan

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_crc(1'b0, 1'b0, 7, 7, 32'h07, 32'h31, 1'b0);
    t_crc(1'b1, 1'b0, 7, 7, 32'he0, 32'h31, 1'b0);
    t_crc(1'b0, 1'b1, 7, 7, 32'h07, 32'h31, 1'b0);
    t_crc(1'b1, 1'b1, 7, 7, 32'he0, 32'h31, 1'b0);
    t_crc(1'b0, 1'b0, 15, 15, 32'h1021, 32'h1234, 1'b1);
    t_scan;
    close_out;
  end
endmodule : crc_engine_control_test
